// *** include/spm_pkg.sv ***
package spm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite bus)
    // ------------------------------------------------------------
    localparam logic [3:0] SPM_OFF_DATA = 4'h0;
    localparam logic [3:0] SPM_OFF_CTRL = 4'h4;
    localparam logic [3:0] SPM_OFF_STAT = 4'h8;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int SPM_CTRL_IRQ_EN   = 7;
    localparam int SPM_CTRL_PORT_EN  = 6;
    localparam int SPM_CTRL_HALVER   = 5;
    localparam int SPM_CTRL_MASTER   = 4;
    localparam int SPM_CTRL_IDLE_LVL = 3;
    localparam int SPM_CTRL_PHASE    = 2;
    localparam int SPM_CTRL_RATE_HI  = 1;
    localparam int SPM_CTRL_RATE_LO  = 0;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int SPM_STAT_DONE  = 7;
    localparam int SPM_STAT_CLASH = 6;
    localparam int SPM_STAT_FAULT = 4;

    // ------------------------------------------------------------
    // Reset values and transfer shape
    // ------------------------------------------------------------
    localparam logic [7:0] SPM_CTRL_RST  = 8'h00;
    localparam logic [7:0] SPM_DATA_RST  = 8'h00;
    localparam logic [4:0] SPM_EDGES     = 5'h10;  // Eight pulses, two edges each

    // ------------------------------------------------------------
    // Serial clock half periods in CPU cycles
    // ------------------------------------------------------------
    localparam logic [6:0] SPM_HALF_DIV8   = 7'h04;
    localparam logic [6:0] SPM_HALF_DIV16  = 7'h08;
    localparam logic [6:0] SPM_HALF_DIV64  = 7'h20;
    localparam logic [6:0] SPM_HALF_DIV128 = 7'h40;

    localparam logic [1:0] SPM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;

endpackage

// *** rtl/spm_port.sv ***
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module spm_port
    import spm_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic        clk,      // CPU clock, 40 MHz
    input  wire logic        rstn,     // Async reset, active low
    // AXI4-Lite slave
    input  wire logic [3:0]  awaddr,   // Write address
    input  wire logic        awvalid,  // Write address valid
    output logic             awready,  // Write address ready
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic [3:0]  wstrb,    // Write byte strobes
    input  wire logic        wvalid,   // Write data valid
    output logic             wready,   // Write data ready
    output logic [1:0]       bresp,    // Write response
    output logic             bvalid,   // Write response valid
    input  wire logic        bready,   // Write response ready
    input  wire logic [3:0]  araddr,   // Read address
    input  wire logic        arvalid,  // Read address valid
    output logic             arready,  // Read address ready
    output logic [31:0]      rdata,    // Read data
    output logic [1:0]       rresp,    // Read response
    output logic             rvalid,   // Read data valid
    input  wire logic        rready,   // Read data ready
    // Serial pins
    input  wire logic        sck_i,    // Serial clock in (slave)
    output logic             sck_o,    // Serial clock out (master)
    output logic             sck_oe,   // Serial clock drive enable
    input  wire logic        mosi_i,   // Master-out line in (slave)
    output logic             mosi_o,   // Master-out line out
    output logic             mosi_oe,  // Master-out drive enable
    input  wire logic        miso_i,   // Master-in line in (master)
    output logic             miso_o,   // Master-in line out
    output logic             miso_oe,  // Master-in drive enable
    input  wire logic        sel_n_i,  // Slave select, active low
    output logic             irq       // Port interrupt, active high
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        done_flag;
        logic        clash_flag;
        logic        fault_flag;
        logic        stat_seen;
        logic        fault_seen;
        logic [7:0]  tx_sh;
        logic [7:0]  rx_sh;
        logic [7:0]  rx_buf;
        logic        busy;
        logic [4:0]  edges;
        logic [6:0]  div;
        logic        sck_lvl;
        logic        sck_prev;
        logic        sel_prev;
        logic        mosi_q;
        logic        miso_q;
        logic        sck_oe_q;
        logic        mosi_oe_q;
        logic        miso_oe_q;
        logic        irq_q;
        logic        aw_have;
        logic [3:0]  aw_addr;
        logic        w_have;
        logic [7:0]  w_byte;
        logic        w_lane;
        logic        aw_rdy;
        logic        w_rdy;
        logic        b_vld;
        logic [1:0]  b_rsp;
        logic        ar_rdy;
        logic        r_vld;
        logic [31:0] r_dat;
        logic [1:0]  r_rsp;
    } spm_state_t;

    localparam spm_state_t SPM_RST = '{
        ctrl: SPM_CTRL_RST, tx_sh: SPM_DATA_RST, rx_sh: SPM_DATA_RST,
        rx_buf: SPM_DATA_RST, aw_addr: 4'h0, w_byte: 8'h00, edges: 5'h00,
        div: 7'h00, b_rsp: SPM_RESP_OKAY, r_rsp: SPM_RESP_OKAY, r_dat: 32'h0,
        aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, sel_prev: 1'b1, default: 1'b0};

    initial begin
        if (SYNC_STAGES < 2) $error("spm_port needs SYNC_STAGES of two or more");
    end

    spm_state_t s_r;
    spm_state_t s_nxt;
    logic       sck_s;
    logic       sel_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    spm_sync #(.STAGES(SYNC_STAGES)) u_sync_sck (
        .clk     (clk),
        .rstn    (rstn),
        .rst_val (1'b0),
        .din     (sck_i),
        .dout    (sck_s)
    );

    spm_sync #(.STAGES(SYNC_STAGES)) u_sync_sel (
        .clk     (clk),
        .rstn    (rstn),
        .rst_val (1'b1),
        .din     (sel_n_i),
        .dout    (sel_s)
    );

    // ------------------------------------------------------------
    // Serial clock rate
    // ------------------------------------------------------------
    function automatic logic [6:0] half_period(input logic [7:0] c);
        logic [6:0] h;
        h = SPM_HALF_DIV8;
        case ({c[SPM_CTRL_RATE_HI], c[SPM_CTRL_RATE_LO]})
            2'b00:   h = SPM_HALF_DIV8;
            2'b01:   h = SPM_HALF_DIV16;
            2'b10:   h = SPM_HALF_DIV64;
            default: h = SPM_HALF_DIV128;
        endcase
        if (c[SPM_CTRL_HALVER]) begin
            h = h >> 1;
        end
        return h;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       en;
        logic       mst;
        logic       ph;
        logic       edge_now;
        logic       sample;
        logic       locked;
        logic       do_wr;
        logic       do_rd;
        logic [3:0] rd_addr;
        logic [4:0] k;
        do_wr   = 1'b0;
        do_rd   = 1'b0;
        rd_addr = araddr;
        k       = 5'h00;
        s_nxt   = s_r;
        en      = s_r.ctrl[SPM_CTRL_PORT_EN];
        mst     = s_r.ctrl[SPM_CTRL_MASTER];
        ph      = s_r.ctrl[SPM_CTRL_PHASE];
        sample  = mst ? miso_i : mosi_i;
        s_nxt.sck_prev = sck_s;
        s_nxt.sel_prev = sel_s;

        // Phase zero slave is locked from select low; otherwise only while shifting
        locked = s_r.busy || (en && !mst && !ph && !sel_s);

        // Serial edge source: own divider in master, synchronised pin in slave
        edge_now = 1'b0;
        if (en && mst && s_r.busy) begin
            if (s_r.div == half_period(s_r.ctrl) - 7'h01) begin
                s_nxt.div     = 7'h00;
                s_nxt.sck_lvl = ~s_r.sck_lvl;
                edge_now      = 1'b1;
            end else begin
                s_nxt.div = s_r.div + 7'h01;
            end
        end else if (en && !mst && !sel_s) begin
            edge_now = (sck_s != s_r.sck_prev);
            if (ph && s_r.edges == 5'h00 && edge_now) begin
                s_nxt.busy = 1'b1;
            end
        end
        if (!(en && mst && s_r.busy)) begin
            s_nxt.sck_lvl = s_r.ctrl[SPM_CTRL_IDLE_LVL];
            s_nxt.div     = 7'h00;
        end

        // Phase zero slave presents its MSB as soon as it is selected
        if (en && !mst && !ph && !sel_s && s_r.sel_prev) begin
            s_nxt.miso_q = s_r.tx_sh[7];
        end

        if (edge_now) begin
            k = s_r.edges + 5'h01;
            s_nxt.edges = k;
            if (k[0] ^ ph) begin
                s_nxt.rx_sh = {s_r.rx_sh[6:0], sample};
            end else if (k != SPM_EDGES) begin
                // Drive edge precedes the capture edge by one
                if (ph && k == 5'h01) begin
                    s_nxt.mosi_q = s_r.tx_sh[7];
                    s_nxt.miso_q = s_r.tx_sh[7];
                end else begin
                    s_nxt.tx_sh  = {s_r.tx_sh[6:0], 1'b0};
                    s_nxt.mosi_q = s_r.tx_sh[6];
                    s_nxt.miso_q = s_r.tx_sh[6];
                end
            end
            if (k == SPM_EDGES) begin
                // Last edge: buffer the byte, newest overwrites an unread one
                s_nxt.rx_buf    = (k[0] ^ ph) ? {s_r.rx_sh[6:0], sample} : s_r.rx_sh;
                s_nxt.done_flag = 1'b1;
                s_nxt.busy      = 1'b0;
                s_nxt.edges     = 5'h00;
            end
        end
        if (!en || (!mst && sel_s)) begin
            if (!mst) begin
                s_nxt.busy  = 1'b0;
                s_nxt.edges = 5'h00;
            end
        end

        // Mode fault: only a master watches its select input
        if (en && mst && !sel_s) begin
            s_nxt.fault_flag                 = 1'b1;
            s_nxt.ctrl[SPM_CTRL_PORT_EN]     = 1'b0;
            s_nxt.ctrl[SPM_CTRL_MASTER]      = 1'b0;
            s_nxt.busy                       = 1'b0;
            s_nxt.edges                      = 5'h00;
        end

        // ------------------------------------------------------------
        // AXI4-Lite write channel
        // ------------------------------------------------------------
        if (awvalid && s_r.aw_rdy) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && s_r.w_rdy) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_byte = wdata[7:0];
            s_nxt.w_lane = wstrb[0];
        end
        if (bready && s_r.b_vld) begin
            s_nxt.b_vld = 1'b0;
        end
        if (s_r.aw_have && s_r.w_have && !s_r.b_vld) begin
            do_wr         = 1'b1;
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.b_vld   = 1'b1;
            s_nxt.b_rsp   = SPM_RESP_OKAY;
        end
        if (do_wr) begin
            case (s_r.aw_addr)
                SPM_OFF_DATA: begin
                    if (s_r.done_flag && !s_r.stat_seen) begin
                        s_nxt.done_flag = s_r.done_flag;
                    end else if (locked) begin
                        s_nxt.clash_flag = 1'b1;
                    end else if (s_r.w_lane) begin
                        if (s_r.stat_seen && !edge_now) begin
                            s_nxt.done_flag = 1'b0;
                        end
                        s_nxt.stat_seen = 1'b0;
                        s_nxt.tx_sh     = s_r.w_byte;
                        if (en && mst) begin
                            s_nxt.busy   = 1'b1;
                            s_nxt.edges  = 5'h00;
                            s_nxt.mosi_q = s_r.w_byte[7];
                        end
                    end
                end
                SPM_OFF_CTRL: begin
                    if (s_r.w_lane) begin
                        s_nxt.ctrl = s_r.w_byte;
                        // A fault raised in this very cycle outlives the clearing write
                        if (s_r.fault_seen && !(en && mst && !sel_s)) begin
                            s_nxt.fault_flag = 1'b0;
                            s_nxt.fault_seen = 1'b0;
                        end else if (s_nxt.fault_flag) begin
                            s_nxt.ctrl[SPM_CTRL_PORT_EN] = 1'b0;
                            s_nxt.ctrl[SPM_CTRL_MASTER]  = 1'b0;
                        end
                    end
                end
                SPM_OFF_STAT: begin
                    if (s_r.fault_flag) begin
                        s_nxt.fault_seen = 1'b1;
                    end
                end
                default: begin
                    s_nxt.b_rsp = SPM_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.aw_rdy = !s_nxt.aw_have && !s_nxt.b_vld;
        s_nxt.w_rdy  = !s_nxt.w_have && !s_nxt.b_vld;

        // ------------------------------------------------------------
        // AXI4-Lite read channel
        // ------------------------------------------------------------
        if (rready && s_r.r_vld) begin
            s_nxt.r_vld = 1'b0;
        end
        if (arvalid && s_r.ar_rdy) begin
            do_rd       = 1'b1;
            s_nxt.r_vld = 1'b1;
            s_nxt.r_rsp = SPM_RESP_OKAY;
            s_nxt.r_dat = 32'h0;
        end
        if (do_rd) begin
            case (rd_addr)
                SPM_OFF_DATA: begin
                    s_nxt.r_dat[7:0] = s_r.rx_buf;
                    if (s_r.stat_seen) begin
                        // A new completion in this cycle keeps its flag
                        if (!(edge_now && k == SPM_EDGES)) begin
                            s_nxt.done_flag = 1'b0;
                        end
                        if (!(do_wr && s_r.aw_addr == SPM_OFF_DATA && locked)) begin
                            s_nxt.clash_flag = 1'b0;
                        end
                        s_nxt.stat_seen = 1'b0;
                    end
                end
                SPM_OFF_CTRL: begin
                    s_nxt.r_dat[7:0] = s_r.ctrl;
                end
                SPM_OFF_STAT: begin
                    s_nxt.r_dat[SPM_STAT_DONE]  = s_r.done_flag;
                    s_nxt.r_dat[SPM_STAT_CLASH] = s_r.clash_flag;
                    s_nxt.r_dat[SPM_STAT_FAULT] = s_r.fault_flag;
                    s_nxt.stat_seen             = 1'b1;
                    if (s_r.fault_flag) begin
                        s_nxt.fault_seen = 1'b1;
                    end
                end
                default: begin
                    s_nxt.r_rsp = SPM_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.ar_rdy = !s_nxt.r_vld;

        // ------------------------------------------------------------
        // Pin drivers, all registered; a disabled port drives nothing
        // ------------------------------------------------------------
        en  = s_nxt.ctrl[SPM_CTRL_PORT_EN];
        mst = s_nxt.ctrl[SPM_CTRL_MASTER];
        s_nxt.sck_oe_q  = en && mst;
        s_nxt.mosi_oe_q = en && mst;
        // Unselected slaves release the line so one device drives it
        s_nxt.miso_oe_q = en && !mst && !sel_s;
        // Interrupt from done or fault only; clash never contributes
        s_nxt.irq_q = s_nxt.ctrl[SPM_CTRL_IRQ_EN] &&
                      (s_nxt.done_flag || s_nxt.fault_flag);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= SPM_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.aw_rdy;
    assign wready  = s_r.w_rdy;
    assign bvalid  = s_r.b_vld;
    assign bresp   = s_r.b_rsp;
    assign arready = s_r.ar_rdy;
    assign rvalid  = s_r.r_vld;
    assign rdata   = s_r.r_dat;
    assign rresp   = s_r.r_rsp;
    assign sck_o   = s_r.sck_lvl;
    assign sck_oe  = s_r.sck_oe_q;
    assign mosi_o  = s_r.mosi_q;
    assign mosi_oe = s_r.mosi_oe_q;
    assign miso_o  = s_r.miso_q;
    assign miso_oe = s_r.miso_oe_q;
    assign irq     = s_r.irq_q;
endmodule // spm_port

// *** rtl/spm_sync.sv ***
`timescale 1ns/100ps
module spm_sync
    import spm_pkg::*;
#(
    parameter int STAGES = 2
) (
    input  wire logic clk,     // CPU clock
    input  wire logic rstn,    // Async reset, active low
    input  wire logic rst_val, // Level held during reset
    input  wire logic din,     // Asynchronous pin level
    output logic      dout     // Level in the clk domain
);
    logic [STAGES-1:0] stage_r;

    initial begin
        if (STAGES < 2) $error("spm_sync needs at least two stages");
    end

    // Only the last stage is looked at outside this module
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_r <= '0;
        end else begin
            stage_r <= {stage_r[STAGES-2:0], din ^ rst_val};
        end
    end

    assign dout = stage_r[STAGES-1] ^ rst_val;
endmodule // spm_sync

// *** verification/spm_peer_model.sv ***
`timescale 1ns/100ps
module spm_peer_model (
    input  wire logic       sck,     // Serial clock from master
    input  wire logic       mosi,    // Master-out line
    input  wire logic       sel_n,   // Select, active low
    input  wire logic       clock_idle_level,    // Idle clock level
    input  wire logic       clock_capture_phase,    // Capture phase
    input  wire logic [7:0] tx_byte, // Byte sent back
    output logic            miso,    // Master-in line
    output logic [7:0]      rx_byte  // Byte captured
);
    // ------------------------------------------------------------
    // Behavioural slave
    // ------------------------------------------------------------
    logic [7:0] sh;
    logic       last;
    int         n;
    always @(negedge sel_n) begin
        sh = tx_byte;
        n = 0;
    end
    // Capture on leading edge for phase 0, trailing for phase 1
    always @(sck) begin
        if (!sel_n) begin
            if ((sck != clock_idle_level) ^ clock_capture_phase) rx_byte = {rx_byte[6:0], mosi};
            else if (!(clock_capture_phase && n == 0)) sh = sh << 1;
            n++;
        end
    end
    always @(sh or sel_n) if (!sel_n) last = sh[7];
    // A released line shows the inverse so stale data cannot pass
    assign miso = sel_n ? ~last : sh[7];
endmodule // spm_peer_model

// *** verification/spm_port_checker.sv ***
`timescale 1ns/100ps
module spm_port_checker (
    input wire logic        clk,      // CPU clock
    input wire logic        rstn,     // Reset, active low
    input wire logic        awvalid,  // Write address valid
    input wire logic        awready,  // Write address ready
    input wire logic        wvalid,   // Write data valid
    input wire logic        wready,   // Write data ready
    input wire logic        bvalid,   // Write response valid
    input wire logic        bready,   // Write response ready
    input wire logic        arvalid,  // Read address valid
    input wire logic        arready,  // Read address ready
    input wire logic        rvalid,   // Read data valid
    input wire logic        rready,   // Read data ready
    input wire logic [31:0] rdata,    // Read data
    input wire logic        sck_o,    // Serial clock out
    input wire logic        sck_oe,   // Serial clock enable
    input wire logic        mosi_oe,  // Master-out enable
    input wire logic        miso_oe,  // Master-in enable
    input wire logic        sel_n_i   // Slave select
);
    // ------------------------------------------------------------
    // Port properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_w_answer; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
    a_w_answer: assert property (p_w_answer) else $error("write response late");
    property p_b_block; bvalid |-> !awready && !wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while answering");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_r_byte; rvalid |-> rdata[31:8] == 24'h000000; endproperty
    a_r_byte: assert property (p_r_byte) else $error("read data wider than a byte");
    property p_oe_pair; sck_oe |-> mosi_oe && !miso_oe; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("master enables mixed");
    property p_fault_off; sck_oe && !sel_n_i |-> ##[1:6] !sck_oe; endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault kept outputs");
    property p_sck_rate; sck_oe && $changed(sck_o) |=> $stable(sck_o); endproperty
    a_sck_rate: assert property (p_sck_rate) else $error("serial clock too fast");
    property p_slave_rel; sel_n_i [*4] |-> !miso_oe; endproperty
    a_slave_rel: assert property (p_slave_rel) else $error("unselected slave drives");
endmodule // spm_port_checker

bind spm_port spm_port_checker u_chk (.clk(clk), .rstn(rstn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .sel_n_i(sel_n_i));

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
    import spm_pkg::*;
    logic        clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, sel_n_i = 1, p_sel_n = 1, p_clock_idle_level = 0, p_clock_capture_phase = 0, miso_i;
    logic        sck_i = 0, mosi_i = 0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0]  p_tx = 8'h00, p_rx;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe;
    logic        mosi_o, mosi_oe, miso_o, miso_oe, irq;
    int          n_fail = 0, n_compared = 0, n_edges = 0, m;

    spm_port dut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
        .sel_n_i(sel_n_i), .irq(irq));
    spm_peer_model peer (.sck(sck_o), .mosi(mosi_o), .sel_n(p_sel_n), .clock_idle_level(p_clock_idle_level),
        .clock_capture_phase(p_clock_capture_phase), .tx_byte(p_tx), .miso(miso_i), .rx_byte(p_rx));

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(sck_o) if (sck_oe) n_edges++;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task guard(input int i);
        if (i >= 200) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task axw(input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        guard(i);
        bready <= 0;
    endtask
    task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        guard(i);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        axr(SPM_OFF_CTRL, d, r);
        chk({24'h0, SPM_CTRL_RST}, d);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h0, d);
        axr(4'hC, d, r);
        chk({30'h0, SPM_RESP_SLVERR}, {30'h0, r});
    endtask
    task t_master(input logic clock_idle_level, input logic clock_capture_phase, input logic [7:0] tx, input logic [7:0] sx);
        logic [31:0] d;
        logic [1:0]  r;
        int          i;
        p_clock_idle_level <= clock_idle_level;
        p_clock_capture_phase <= clock_capture_phase;
        p_tx <= sx;
        axw(SPM_OFF_CTRL, {4'b1101, clock_idle_level, clock_capture_phase, 2'b00});
        repeat (2) @(posedge clk);
        chk({31'h0, clock_idle_level}, {31'h0, sck_o});
        // Select only after the idle level settled, so the peer sees no false edge
        p_sel_n <= 0;
        n_edges = 0;
        axw(SPM_OFF_DATA, tx);
        // Second write lands mid-byte and must be thrown away
        axw(SPM_OFF_DATA, ~tx);
        chk(32'h0, {31'h0, irq});
        for (i = 0; i < 200; i++) begin
            axr(SPM_OFF_STAT, d, r);
            if (d[SPM_STAT_DONE] === 1'b1) break;
        end
        guard(i);
        chk(32'hC0, d);
        chk(32'h1, {31'h0, irq});
        axr(SPM_OFF_DATA, d, r);
        chk({24'h0, sx}, d);
        chk({24'h0, tx}, {24'h0, p_rx});
        chk(32'd16, n_edges);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h0, d);
        chk({31'h0, clock_idle_level}, {31'h0, sck_o});
        p_sel_n <= 1;
        repeat (4) @(posedge clk);
    endtask
    task t_fault;
        logic [31:0] d;
        logic [1:0]  r;
        axw(SPM_OFF_CTRL, 8'hD0);
        sel_n_i <= 0;
        repeat (8) @(posedge clk);
        chk(32'h1, {31'h0, irq});
        chk(32'h0, {31'h0, sck_oe});
        axw(SPM_OFF_CTRL, 8'hD0);
        axr(SPM_OFF_CTRL, d, r);
        chk(32'h80, d);
        sel_n_i <= 1;
        axr(SPM_OFF_STAT, d, r);
        chk(32'h10, d);
        axw(SPM_OFF_CTRL, 8'h40);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h0, d);
        sel_n_i <= 0;
        repeat (8) @(posedge clk);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h0, d);
        axw(SPM_OFF_DATA, 8'h5A);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h40, d);
        axr(SPM_OFF_DATA, d, r);
        sel_n_i <= 1;
    endtask
    task t_slave(input logic [7:0] tx, input logic [7:0] mx);
        logic [31:0] d;
        logic [1:0]  r;
        int          i;
        axw(SPM_OFF_CTRL, 8'h44);
        axw(SPM_OFF_DATA, tx);
        sel_n_i <= 0;
        repeat (4) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            sck_i <= 1;
            mosi_i <= mx[7 - i];
            repeat (4) @(posedge clk);
            chk({31'h0, tx[7 - i]}, {31'h0, miso_o});
            sck_i <= 0;
            repeat (4) @(posedge clk);
        end
        axr(SPM_OFF_STAT, d, r);
        chk(32'h80, d);
        axr(SPM_OFF_DATA, d, r);
        chk({24'h0, mx}, d);
        // Select stays low into the next byte
        axw(SPM_OFF_DATA, mx);
        axr(SPM_OFF_STAT, d, r);
        chk(32'h0, d);
        sel_n_i <= 1;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        t_reset();
        for (m = 0; m < 4; m++) t_master(m[1], m[0], 8'h96 + m[7:0], 8'h4B + m[7:0]);
        t_fault();
        t_slave(8'hA5, 8'h3C);
        end_of_test();
    end
endmodule // tb
